// file: hw/ssh_handler.sv
// monitoring subcommand handler: decodes b0h subcommands, keeps the
// autosave flag, runs threshold read, save and off-line/captive launch
// assumes one command strobe at a time and an external nv store and
// self-test engine with simple pulse handshakes
`timescale 1ns/100ps
module ssh_handler
  import ssh_pkg::*;
#(
  parameter int YIELD_LIMIT = YIELD_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // command from host front end
  input wire logic cmd_valid_in,
  input wire ssh_cmd_t cmd_in,
  output logic cmd_ready_out,
  // completion to host
  output logic busy_out,
  output logic intrq_out,
  output ssh_resp_t resp_out,
  // device condition flags
  input wire logic dev_fault_in,
  input wire logic sense_avail_in,
  input wire logic align_err_in,
  // threshold words in, 16-bit data-in stream out
  output logic [7:0] thr_addr_out,
  input wire logic [15:0] thr_word_in,
  output logic din_valid_out,
  output logic [15:0] din_data_out,
  input wire logic din_ready_in,
  // non-volatile autosave flag
  input wire logic nv_flag_in,
  output logic nv_wr_out,
  output logic nv_flag_out,
  output logic autosave_en_out,
  // attribute store and normal-event saves
  input wire logic power_event_in,
  output logic attr_save_out,
  // self-test engine
  output logic test_start_out,
  output logic [7:0] test_sel_out,
  output logic test_abort_out,
  input wire logic test_done_in,
  input wire logic test_fail_in,
  output logic test_yield_out
);
  ////////////////////////////////////////////////////////////////////////
  ssh_state_t state_ff, nxt_state;
  logic as_ff, nxt_as;
  logic [8:0] wcnt_ff, nxt_wcnt;
  ssh_resp_t resp_ff, nxt_resp;
  logic intrq_ff, nxt_intrq;
  logic nvw_ff, nxt_nvw;
  logic save_ff, nxt_save;
  logic start_ff, nxt_start;
  logic abort_ff, nxt_abort;
  logic [7:0] sel_ff, nxt_sel;
  logic offl_ff, nxt_offl;
  logic [31:0] ycnt_ff, nxt_ycnt;
  logic yield_ff, nxt_yield;
  logic sk_ready, push;
  logic sig_ok, sel_ok, sel_capt;
  logic [7:0] sel;

  assign sel = cmd_in.lba[7:0];
  assign sig_ok = (cmd_in.opcode == OPC_MONITOR) &&
    (cmd_in.lba[23:8] == SIG_OK);
  assign sel_ok = (sel == SEL_COLLECT) || (sel == SEL_SHORT) ||
    (sel == SEL_EXTEND) || (sel == SEL_SELECT) || (sel == SEL_ABORT) ||
    (sel == (SEL_CAPTIVE | SEL_SHORT)) ||
    (sel == (SEL_CAPTIVE | SEL_EXTEND)) ||
    (sel == (SEL_CAPTIVE | SEL_SELECT));
  assign sel_capt = sel[7];

  assign cmd_ready_out = (state_ff == ST_IDLE);
  assign push = (state_ff == ST_XFER) && sk_ready;
  assign thr_addr_out = wcnt_ff[7:0];

  // status bits follow live condition inputs
  function automatic logic [7:0] mk_status(input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[STS_FAULT] = dev_fault_in;
    s[STS_SENSE] = sense_avail_in;
    s[STS_ALIGN] = align_err_in;
    s[STS_ERR] = err;
    return s;
  endfunction : mk_status

  function automatic ssh_resp_t mk_resp(input logic err,
                                        input logic [15:0] sig);
    ssh_resp_t r;
    r = '0;
    r.status = mk_status(err);
    r.error[ERR_ABORT] = err;
    r.lba[23:8] = sig;
    return r;
  endfunction : mk_resp

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_as = as_ff;
    nxt_wcnt = wcnt_ff;
    nxt_resp = resp_ff;
    nxt_intrq = 1'b0;
    nxt_nvw = 1'b0;
    nxt_save = power_event_in;
    nxt_start = 1'b0;
    nxt_abort = 1'b0;
    nxt_sel = sel_ff;
    nxt_offl = offl_ff;
    nxt_ycnt = ycnt_ff;
    nxt_yield = 1'b0;
    if (offl_ff && test_done_in) begin
      nxt_offl = 1'b0;
    end
    case (state_ff)
      ST_LOAD: begin
        nxt_as = nv_flag_in;
        nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (cmd_valid_in) begin
          nxt_state = ST_DONE;
          nxt_resp = mk_resp(1'b0, SIG_OK);
          // a new command pulls an off-line routine aside
          if (offl_ff) begin
            nxt_yield = 1'b1;
            nxt_ycnt = 32'd0;
          end
          if (!sig_ok) begin
            nxt_resp = mk_resp(1'b1, SIG_OK);
          end else begin
            case (cmd_in.feature)
              SUB_RD_THR: begin
                nxt_state = ST_XFER;
                nxt_wcnt = 9'd0;
              end
              SUB_AUTOSAVE: begin
                nxt_state = ST_BUSY;
                if (cmd_in.count == CNT_AS_OFF) begin
                  nxt_as = 1'b0;
                  nxt_nvw = 1'b1;
                end else if (cmd_in.count == CNT_AS_ON) begin
                  nxt_as = 1'b1;
                  nxt_nvw = 1'b1;
                end else begin
                  nxt_resp = mk_resp(1'b1, SIG_OK);
                end
              end
              SUB_SAVE: begin
                nxt_save = 1'b1;
              end
              SUB_DISABLE: begin
                nxt_as = 1'b0;
                nxt_nvw = 1'b1;
              end
              SUB_OFFLINE: begin
                if (!sel_ok) begin
                  nxt_resp = mk_resp(1'b1, SIG_OK);
                end else if (sel == SEL_ABORT) begin
                  nxt_abort = 1'b1;
                  nxt_offl = 1'b0;
                  nxt_resp = mk_resp(1'b0, SIG_OFFLINE);
                end else if (sel_capt) begin
                  nxt_start = 1'b1;
                  nxt_sel = sel;
                  nxt_state = ST_CAPT;
                end else begin
                  nxt_start = 1'b1;
                  nxt_sel = sel;
                  nxt_offl = 1'b1;
                  nxt_resp = mk_resp(1'b0, SIG_OFFLINE);
                end
              end
              default: begin
                nxt_resp = mk_resp(1'b1, SIG_OK);
              end
            endcase
          end
        end
      end
      ST_BUSY: begin
        nxt_state = ST_DONE;
      end
      ST_XFER: begin
        if (sk_ready) begin
          nxt_wcnt = wcnt_ff + 9'd1;
          if (wcnt_ff == 9'(XFER_WORDS - 1)) begin
            nxt_state = ST_DONE;
          end
        end
      end
      ST_CAPT: begin
        if (test_done_in) begin
          if (test_fail_in) begin
            nxt_resp = mk_resp(1'b1, SIG_FAIL);
          end else begin
            nxt_resp = mk_resp(1'b0, SIG_OK);
          end
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_intrq = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // yield must be seen within the two-second window
    if (offl_ff && (state_ff != ST_IDLE) && (ycnt_ff < YIELD_LIMIT)) begin
      nxt_ycnt = ycnt_ff + 32'd1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_ff <= ST_LOAD;
      as_ff <= 1'b0;
      wcnt_ff <= 9'd0;
      resp_ff <= '0;
      intrq_ff <= 1'b0;
      nvw_ff <= 1'b0;
      save_ff <= 1'b0;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      sel_ff <= 8'h00;
      offl_ff <= 1'b0;
      ycnt_ff <= 32'd0;
      yield_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      as_ff <= nxt_as;
      wcnt_ff <= nxt_wcnt;
      resp_ff <= nxt_resp;
      intrq_ff <= nxt_intrq;
      nvw_ff <= nxt_nvw;
      save_ff <= nxt_save;
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
      sel_ff <= nxt_sel;
      offl_ff <= nxt_offl;
      ycnt_ff <= nxt_ycnt;
      yield_ff <= nxt_yield;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer keeps words when the host stalls the data-in phase
  ssh_skid #(
    .WIDTH(16)
  ) u_skid (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .in_valid_in(push),
    .in_data_in(thr_word_in),
    .in_ready_out(sk_ready),
    .out_valid_out(din_valid_out),
    .out_data_out(din_data_out),
    .out_ready_in(din_ready_in)
  );

  // busy also covers reset load so no command lands before the flag
  assign busy_out = (state_ff != ST_IDLE);
  assign intrq_out = intrq_ff;
  assign resp_out = resp_ff;
  assign nv_wr_out = nvw_ff;
  assign nv_flag_out = as_ff;
  assign autosave_en_out = as_ff;
  assign attr_save_out = save_ff;
  assign test_start_out = start_ff;
  assign test_sel_out = sel_ff;
  assign test_abort_out = abort_ff;
  assign test_yield_out = yield_ff;
endmodule : ssh_handler

// file: hw/ssh_pkg.sv
// constants and carrier types for the monitoring subcommand handler
// assumes a command front end that delivers decoded ata command fields
//
// Behaviour
// - threshold read sends exactly 512 bytes
// - autosave needs b0h, d2h and signature c24fh
// - count 00h clears autosave enable
// - count f1h sets autosave enable
// - other count keeps state, reports error
// - autosave state kept across power cycles
// - normal-event saves allowed with autosave off
// - monitoring disable also clears autosave
// - autosave: busy, update, clear busy, interrupt
// - save subcommand writes attributes regardless
// - off-line selector decoded from lba 7:0
// - captive pass returns c24fh in 23:8
// - status bits: fault 5, sense 1, error 0
// - status bit 2 is alignment error or unused
// - selectors 0,1,2,4,127,129,130,132 defined
// - captive holds busy until result recorded
// - captive fail 2cf4h; other errors c24fh abort
package ssh_pkg;
  localparam logic [7:0] OPC_MONITOR = 8'hb0;
  localparam logic [7:0] SUB_RD_ATTR = 8'hd0;
  localparam logic [7:0] SUB_RD_THR = 8'hd1;
  localparam logic [7:0] SUB_AUTOSAVE = 8'hd2;
  localparam logic [7:0] SUB_SAVE = 8'hd3;
  localparam logic [7:0] SUB_OFFLINE = 8'hd4;
  localparam logic [7:0] SUB_DISABLE = 8'hd9;
  localparam logic [15:0] SIG_OK = 16'hc24f;
  localparam logic [15:0] SIG_FAIL = 16'h2cf4;
  localparam logic [15:0] SIG_OFFLINE = 16'h0000;
  localparam logic [7:0] CNT_AS_OFF = 8'h00;
  localparam logic [7:0] CNT_AS_ON = 8'hf1;
  localparam logic [7:0] SEL_COLLECT = 8'h00;
  localparam logic [7:0] SEL_SHORT = 8'h01;
  localparam logic [7:0] SEL_EXTEND = 8'h02;
  localparam logic [7:0] SEL_SELECT = 8'h04;
  localparam logic [7:0] SEL_ABORT = 8'h7f;
  localparam logic [7:0] SEL_CAPTIVE = 8'h80;
  localparam int XFER_BYTES = 512;
  localparam int XFER_WORDS = XFER_BYTES / 2;
  localparam int STS_FAULT = 5;
  localparam int STS_ALIGN = 2;
  localparam int STS_SENSE = 1;
  localparam int STS_ERR = 0;
  localparam int ERR_ABORT = 2;
  localparam int CLK_HZ = 40_000_000;
  localparam int YIELD_MS = 2000;
  localparam int YIELD_CYC = (CLK_HZ / 1000) * YIELD_MS;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
    logic [7:0] count;
    logic [27:0] lba;
  } ssh_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [27:0] lba;
  } ssh_resp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_XFER = 3'b011,
    ST_CAPT = 3'b010,
    ST_DONE = 3'b110,
    ST_LOAD = 3'b100
  } ssh_state_t;
endpackage : ssh_pkg

// file: hw/ssh_skid.sv
// two-entry buffer between the word source and the data-in port
// assumes the receiver may drop ready at any cycle
`timescale 1ns/100ps
module ssh_skid #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  logic [1:0][WIDTH-1:0] mem_ff, nxt_mem;
  logic [1:0] cnt_ff, nxt_cnt;
  logic rd_ff, nxt_rd;
  logic wr_ff, nxt_wr;
  logic push, pop;

  assign in_ready_out = (cnt_ff != 2'd2);
  assign out_valid_out = (cnt_ff != 2'd0);
  assign out_data_out = mem_ff[rd_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_cnt = cnt_ff;
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data_in;
      nxt_wr = ~wr_ff;
    end
    if (pop) begin
      nxt_rd = ~rd_ff;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'd1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'd1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mem_ff <= '0;
      cnt_ff <= 2'd0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      mem_ff <= nxt_mem;
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
    end
  end
endmodule : ssh_skid

// file: bench/ssh_handler_asserts.sv
// concurrent checks on the monitoring subcommand handler ports
// assumes binding onto ssh_handler, one clock domain
`timescale 1ns/100ps
module ssh_handler_asserts
  import ssh_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // command and completion
  input wire logic cmd_valid_in,
  input wire ssh_cmd_t cmd_in,
  input wire logic cmd_ready_out,
  input wire logic busy_out,
  input wire logic intrq_out,
  input wire ssh_resp_t resp_out,
  // flags, stream, autosave, self-test
  input wire logic dev_fault_in,
  input wire logic sense_avail_in,
  input wire logic din_valid_out,
  input wire logic din_ready_in,
  input wire logic autosave_en_out,
  input wire logic nv_wr_out,
  input wire logic power_event_in,
  input wire logic attr_save_out,
  input wire logic test_start_out,
  input wire logic [7:0] test_sel_out,
  input wire logic test_done_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic take;
  logic thr_ff;
  logic [9:0] wcnt_ff;
  assign take = cmd_valid_in && cmd_ready_out &&
    cmd_in.opcode == OPC_MONITOR && cmd_in.lba[23:8] == SIG_OK;
  ////////////////////////////////////////////////////////////////////////
  // words handed over since the last accepted command
  always_ff @(posedge core_clk_in) begin
    if (srst_in || take) begin
      wcnt_ff <= 10'h0;
      thr_ff <= take && cmd_in.feature == SUB_RD_THR;
    end else if (din_valid_out && din_ready_in) begin
      wcnt_ff <= wcnt_ff + 10'h1;
    end
  end
  sequence s_as(logic [7:0] c);
    take && cmd_in.feature == SUB_AUTOSAVE && cmd_in.count == c;
  endsequence
  sequence s_done;
    ##[0:2] intrq_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_as_on: assert property (s_as(CNT_AS_ON) |->
    ##[1:2] (busy_out && autosave_en_out && nv_wr_out) ##1 s_done)
    else $error("autosave enable sequence wrong");
  a_as_off: assert property (s_as(CNT_AS_OFF) |->
    ##[1:3] !autosave_en_out) else $error("autosave not cleared");
  a_as_keep: assert property (take && cmd_in.feature == SUB_AUTOSAVE &&
    cmd_in.count != CNT_AS_OFF && cmd_in.count != CNT_AS_ON |=>
    $stable(autosave_en_out) [*3] ##0 s_done ##0 resp_out.status[STS_ERR])
    else $error("bad count handled wrongly");
  a_err_abort: assert property (intrq_out && resp_out.status[STS_ERR]
    |-> resp_out.error[ERR_ABORT]) else $error("error without abort");
  a_sts_copy: assert property (intrq_out |->
    resp_out.status[STS_FAULT] == $past(dev_fault_in) &&
    resp_out.status[STS_SENSE] == $past(sense_avail_in))
    else $error("status flags not copied");
  a_busy_excl: assert property (busy_out |-> !cmd_ready_out)
    else $error("ready while busy");
  a_capt_hold: assert property (test_start_out && test_sel_out[7] |->
    (busy_out && !intrq_out) [*4]) else $error("captive left busy early");
  // an off-line routine may finish while another command is busy
  a_capt_done: assert property (test_done_in && busy_out &&
    test_sel_out[7] |-> ##[1:3] intrq_out)
    else $error("captive completion missing");
  // words still drain after the pulse, so the count is judged at the
  // next accepted command
  a_thr_len: assert property (take && thr_ff |->
    wcnt_ff == 10'h100) else $error("threshold length wrong");
  a_thr_max: assert property (thr_ff |-> wcnt_ff <= 10'h100)
    else $error("threshold transfer too long");
  a_pwr_save: assert property (power_event_in |->
    ##[1:2] attr_save_out) else $error("power event save missing");
  a_intrq_pulse: assert property (intrq_out |=> !intrq_out)
    else $error("interrupt longer than one cycle");
endmodule : ssh_handler_asserts
bind ssh_handler ssh_handler_asserts u_chk (.*);

// file: bench/ssh_far_model.sv
// far side model: stored flag, threshold table, self-test engine
// assumes the handler's pulse handshakes on one clock
`timescale 1ns/100ps
module ssh_far_model (
  // clock
  input wire logic core_clk_in,
  // from handler, fail mode from the bench
  input wire logic start_in,
  input wire logic [7:0] sel_in,
  input wire logic stop_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic flag_in,
  input wire logic fail_mode_in,
  // to handler
  output logic done_out,
  output logic fail_out,
  output logic [15:0] word_out,
  output logic flag_out
);
  logic [5:0] cnt_ff = 6'h0;
  // no reset: the stored flag must outlive a power cycle
  logic nv_ff = 1'b1;
  always @(posedge core_clk_in) begin
    if (wr_in) nv_ff <= flag_in;
    if (start_in) cnt_ff <= sel_in[7] ? 6'h6 : 6'h28;
    else if (stop_in) cnt_ff <= 6'h0;
    else if (cnt_ff != 6'h0) cnt_ff <= cnt_ff - 6'h1;
  end
  assign done_out = cnt_ff == 6'h1;
  assign fail_out = fail_mode_in;
  assign word_out = {8'ha5, addr_in};
  assign flag_out = nv_ff;
endmodule : ssh_far_model

// file: bench/test_smart_subcommand_handler.sv
// self-checking bench for the monitoring subcommand handler
// assumes ssh_far_model stands in for storage and self-test engine
`timescale 1ns/100ps
module test_smart_subcommand_handler
  import ssh_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, din_ready = 1'b0;
  logic dev_fault = 1'b0, sense = 1'b0, align = 1'b0, pwr = 1'b0;
  logic fail_mode = 1'b0;
  ssh_cmd_t cmd = '0;
  ssh_resp_t resp;
  logic cmd_ready, busy, intrq, din_valid, nv_wr, nv_flag, nv_in, as_en;
  logic attr_save, t_start, t_abort, t_done, t_fail, t_yield;
  logic [7:0] thr_addr, t_sel;
  logic [15:0] thr_word, din_data;
  int error_cnt = 0, checked = 0, widx = 0, saves = 0, yields = 0;
  int starts = 0, aborts = 0, cyc = 0, s;
  logic [7:0] bad [4] = '{8'h01, 8'hf0, 8'hf2, 8'hff};
  logic [7:0] offs [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h7f};
  logic [7:0] capt [3] = '{8'h81, 8'h82, 8'h84};
  initial begin
    forever #12.5 clk = ~clk;
  end
  ssh_handler #(.YIELD_LIMIT(100)) dut (
    .core_clk_in(clk), .srst_in(rst), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .cmd_ready_out(cmd_ready), .busy_out(busy),
    .intrq_out(intrq), .resp_out(resp), .dev_fault_in(dev_fault),
    .sense_avail_in(sense), .align_err_in(align),
    .thr_addr_out(thr_addr), .thr_word_in(thr_word),
    .din_valid_out(din_valid), .din_data_out(din_data),
    .din_ready_in(din_ready), .nv_flag_in(nv_in), .nv_wr_out(nv_wr),
    .nv_flag_out(nv_flag), .autosave_en_out(as_en),
    .power_event_in(pwr), .attr_save_out(attr_save),
    .test_start_out(t_start), .test_sel_out(t_sel),
    .test_abort_out(t_abort), .test_done_in(t_done),
    .test_fail_in(t_fail), .test_yield_out(t_yield));
  ssh_far_model far (.core_clk_in(clk), .start_in(t_start),
    .sel_in(t_sel), .stop_in(t_abort | t_yield), .addr_in(thr_addr),
    .wr_in(nv_wr), .flag_in(nv_flag), .fail_mode_in(fail_mode),
    .done_out(t_done), .fail_out(t_fail), .word_out(thr_word),
    .flag_out(nv_in));
  ////////////////////////////////////////////////////////////////////////
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task chk1(input logic got, input logic exp);
    chk16({15'h0, got}, {15'h0, exp});
  endtask : chk1
  task final_report;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task do_reset;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  // one command, waits for its completion pulse
  task send(input logic [7:0] f, input logic [7:0] c, input logic [27:0] l);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    cmd = '{OPC_MONITOR, f, c, l};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (intrq !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask : send
  ////////////////////////////////////////////////////////////////////////
  // receiver ready one cycle in four so the buffer fills and refuses
  always @(negedge clk) din_ready <= cyc[1:0] == 2'h0;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (din_valid && din_ready) begin
      chk16(din_data, {8'ha5, widx[7:0]});
      widx <= widx + 1;
    end
    if (attr_save) saves <= saves + 1;
    if (t_yield) yields <= yields + 1;
    if (t_start) starts <= starts + 1;
    if (t_abort) aborts <= aborts + 1;
    if (cyc > 30000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    do_reset;
    @(negedge clk);
    chk1(as_en, 1'b1);
    send(SUB_AUTOSAVE, CNT_AS_OFF, {4'h0, SIG_OK, 8'h00});
    chk1(as_en, 1'b0);
    chk1(resp.status[STS_ERR], 1'b0);
    // a cleared flag must survive reset, not fall back to the default
    do_reset;
    @(negedge clk);
    chk1(as_en, 1'b0);
    send(SUB_AUTOSAVE, CNT_AS_ON, {4'h0, SIG_OK, 8'h00});
    chk1(as_en, 1'b1);
    do_reset;
    @(negedge clk);
    chk1(as_en, 1'b1);
    foreach (bad[i]) begin
      send(SUB_AUTOSAVE, bad[i], {4'h0, SIG_OK, 8'h00});
      chk1(as_en, 1'b1);
      chk1(resp.status[STS_ERR], 1'b1);
    end
    send(SUB_AUTOSAVE, CNT_AS_OFF, {4'h0, 16'h1234, 8'h00});
    chk1(as_en, 1'b1);
    chk16(resp.lba[23:8], SIG_OK);
    chk1(resp.error[ERR_ABORT], 1'b1);
    send(SUB_DISABLE, 8'h00, {4'h0, SIG_OK, 8'h00});
    chk1(as_en, 1'b0);
    $display("test autosave done");
    s = saves;
    send(SUB_SAVE, 8'h00, {4'h0, SIG_OK, 8'h00});
    @(negedge clk);
    chk16(16'(saves - s), 16'h1);
    pwr = 1'b1;
    @(negedge clk);
    pwr = 1'b0;
    repeat (3) @(negedge clk);
    chk16(16'(saves - s), 16'h2);
    widx = 0;
    send(SUB_RD_THR, 8'h00, {4'h0, SIG_OK, 8'h00});
    repeat (20) @(negedge clk);
    chk16(16'(widx), 16'h100);
    $display("test save and thresholds done");
    {dev_fault, sense, align} = 3'h7;
    foreach (offs[i]) begin
      send(SUB_OFFLINE, 8'h00, {4'h0, SIG_OK, offs[i]});
      chk1(resp.status[STS_ERR], 1'b0);
      chk1(resp.lba[23:8] == SIG_OK, 1'b0);
      chk1(resp.status[STS_FAULT], 1'b1);
      chk1(resp.status[STS_SENSE], 1'b1);
      chk1(resp.status[STS_ALIGN], 1'b1);
    end
    chk16(16'(aborts), 16'h1);
    {dev_fault, sense, align} = 3'h0;
    s = yields;
    send(SUB_OFFLINE, 8'h00, {4'h0, SIG_OK, SEL_SHORT});
    send(SUB_SAVE, 8'h00, {4'h0, SIG_OK, 8'h00});
    chk1(yields != s, 1'b1);
    foreach (capt[i]) begin
      send(SUB_OFFLINE, 8'h00, {4'h0, SIG_OK, capt[i]});
      chk16(resp.lba[23:8], SIG_OK);
    end
    fail_mode = 1'b1;
    send(SUB_OFFLINE, 8'h00, {4'h0, SIG_OK, 8'h81});
    chk16(resp.lba[23:8], SIG_FAIL);
    fail_mode = 1'b0;
    s = starts;
    send(SUB_OFFLINE, 8'h00, {4'h0, SIG_OK, 8'h03});
    chk1(resp.error[ERR_ABORT], 1'b1);
    chk16(16'(starts - s), 16'h0);
    $display("test off-line and captive done");
    final_report;
  end
endmodule : test_smart_subcommand_handler
